// *** dv/ldpwm_ssr_model.sv ***
// Solid-state relay load model: counts on-time and shortest on and off runs
module ldpwm_ssr_model (
    input  wire logic pclk,
    input  wire logic ssr_drive,
    input  wire logic clr,
    output int        on_cycles,
    output int        min_on_run,
    output int        min_off_run
);
    timeunit 1ns;
    timeprecision 1ns;
    int   run;
    logic last;
    logic seen;
    // Partial runs cut by a clear are never recorded, only whole ones
    always @(posedge pclk) begin
        if (clr) begin
            on_cycles   <= 0;
            run         <= 0;
            seen        <= 1'b0;
            min_on_run  <= 1000000;
            min_off_run <= 1000000;
        end else begin
            on_cycles <= on_cycles + int'(ssr_drive === 1'b1);
            if (ssr_drive !== last) begin
                if (seen && last === 1'b1 && run < min_on_run) min_on_run <= run;
                if (seen && last === 1'b0 && run < min_off_run) min_off_run <= run;
                seen <= 1'b1;
                run  <= 1;
            end else begin
                run <= run + 1;
            end
        end
        last <= ssr_drive;
    end
endmodule : ldpwm_ssr_model

// *** dv/level_driven_pwm_output_tb.sv ***
// Self-checking bench for the level-driven PWM output
module level_driven_pwm_output_tb
    import ldpwm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value %s exp %0h got %0h", n, e, g); end end
    // ****************************************
    // Signals and instances
    // ****************************************
    localparam int TC  = 4;
    localparam int NCH = 4;
    logic              pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, clr = 1;
    logic              pready, pslverr, ssr_drive, er;
    logic [7:0]        paddr = 0;
    logic [31:0]       pwdata = 0, prdata, rd, seed = 32'd67761;
    logic [NCH*16-1:0] ch_value = 0, cv;
    logic [NCH-1:0]    err_st = 0, und_st = 0, ovr_st = 0;
    int                on_cycles, min_on_run, min_off_run, v;
    int                fail_count = 0, check_count = 0;

    ldpwm_output #(.NCH(NCH), .VW(16), .TICK_COUNT(TC)) u_ldpwm_output (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .ch_value(ch_value), .source_error_state(err_st),
        .source_under_range_state(und_st), .source_over_range_state(ovr_st),
        .ssr_drive(ssr_drive));
    ldpwm_ssr_model u_ldpwm_ssr_model (.pclk(pclk), .ssr_drive(ssr_drive), .clr(clr),
        .on_cycles(on_cycles), .min_on_run(min_on_run), .min_off_run(min_off_run));

    initial forever #50 pclk = ~pclk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic int exp_on(input int s, input int l, input int u, input int p);
        if (s < l) return 0;
        if (s > u || u == l) return p;
        return (s - l) * p / (u - l);
    endfunction : exp_on

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the slave
        do begin @(posedge pclk); end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Settle two periods so the new duty is loaded, then count one whole period
    task automatic measure(input int p, input int s);
        cv = {rnd(), rnd()};
        cv[32 +: 16] = s[15:0];
        ch_value <= cv;
        repeat (2 * p * TC) @(posedge pclk);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        // One extra edge lets the model's last count settle before it is read
        repeat (p * TC + 1) @(posedge pclk);
    endtask : measure

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (80000) @(posedge pclk);
        fail_count++;
        print_verdict();
    end

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, OFS_PERIOD, 0); `CHK("period reset", 32'h0000_03E8, rd)
        apb(0, OFS_UPPER, 0); `CHK("upper reset", 32'h0000_0064, rd)
        apb(0, 8'h30, 0); `CHK("unmapped error", 1'b1, er)
        apb(1, OFS_PERIOD, 99);
        apb(0, OFS_PERIOD, 0); `CHK("short period kept out", 32'h0000_03E8, rd)
        apb(0, OFS_STATUS, 0); `CHK("period refused", 1'b1, rd[ST_REFUSED_BIT])
        apb(1, OFS_PERIOD, 100);
        apb(0, OFS_PERIOD, 0); `CHK("min period taken", 32'h0000_0064, rd)
        apb(1, OFS_SRC_SEL, 2);
        for (int t = 1; t < 4; t++) begin
            apb(1, OFS_CTRL, 32'(4 * t + 1));
            apb(0, OFS_CTRL, 0); `CHK("non-SSR enable", 1'b0, rd[CTRL_EN_BIT])
            `CHK("type kept", t[1:0], rd[CTRL_TYPE_LSB +: 2])
        end
        apb(1, OFS_CTRL, 1);
        $display("test registers done");
        for (int i = 0; i < 14; i++) begin
            v = (i == 0) ? -5 : (i == 1) ? 0 : (i == 2) ? 150 : int'(rnd() % 99) + 1;
            measure(100, v);
            `CHK("on cycles", exp_on(v, 0, 100, 100) * TC, on_cycles)
        end
        $display("test level mapping done");
        apb(1, OFS_ALARM, 40);
        for (int k = 0; k < 3; k++) begin
            err_st <= (k == 0) ? 4'h4 : 4'h0;
            und_st <= (k == 1) ? 4'h4 : 4'h0;
            ovr_st <= (k == 2) ? 4'h4 : 4'h0;
            measure(100, 150);
            `CHK("alarm on cycles", 40 * TC, on_cycles)
            apb(0, OFS_STATUS, 0); `CHK("alarm flag", 1'b1, rd[ST_ALARM_BIT])
        end
        ovr_st <= 4'h0;
        $display("test alarm done");
        apb(1, OFS_PERIOD, 200);
        apb(1, OFS_LOWER, 20);
        apb(1, OFS_UPPER, 60);
        measure(200, 50); `CHK("long period on", 150 * TC, on_cycles)
        apb(0, OFS_DUTY, 0); `CHK("duty word", 32'h0096_0096, rd)
        apb(1, OFS_PERIOD, 100);
        apb(1, OFS_LOWER, 0);
        apb(1, OFS_UPPER, 100);
        apb(1, OFS_MIN_ON, 30);
        // Two whole periods are counted so that one complete pulse always lies inside
        measure(200, 5); `CHK("min on", 30 * TC, min_on_run)
        apb(1, OFS_MIN_ON, 0);
        apb(1, OFS_MIN_OFF, 30);
        measure(200, 95); `CHK("min off", 30 * TC, min_off_run)
        $display("test timing done");
        print_verdict();
    end
endmodule : level_driven_pwm_output_tb

// *** hdl/ldpwm_duty.sv ***
// Maps a source value onto the on-time of one period
module ldpwm_duty
    import ldpwm_pkg::*;
#(
    parameter int VW = 16,
    parameter int CW = 16
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          start,
    input  wire logic [VW-1:0] value,
    input  wire logic [VW-1:0] lower,
    input  wire logic [VW-1:0] upper,
    input  wire logic [CW-1:0] period,
    output logic               done,
    output logic [CW-1:0]      on_ticks
);
    typedef struct packed {
        logic               busy;
        logic               done;
        logic [5:0]         cnt;
        logic [VW+1:0]      rem;
        logic [VW+CW-1:0]   quo;
        logic [VW:0]        den;
        logic [CW-1:0]      on_ticks;
    } ldpwm_div_t;

    ldpwm_div_t st_reg, st_next;
    logic [VW:0] diff, span;
    logic [VW+1:0] rem_s;

    assign diff = {value[VW-1], value} - {lower[VW-1], lower};
    assign span = {upper[VW-1], upper} - {lower[VW-1], lower};

    always_comb begin
        st_next      = st_reg;
        st_next.done = 1'b0;
        rem_s        = {st_reg.rem[VW:0], st_reg.quo[VW+CW-1]};
        if (!st_reg.busy) begin
            if (start) begin
                if ($signed(value) < $signed(lower)) begin
                    st_next.on_ticks = '0;                        // [R3]
                    st_next.done     = 1'b1;
                end else if ($signed(value) > $signed(upper) || span == '0) begin
                    st_next.on_ticks = period;                    // [R4]
                    st_next.done     = 1'b1;
                end else begin
                    // (value - lower) * period / (upper - lower), long division
                    st_next.busy = 1'b1;                          // [R13] [R6]
                    st_next.cnt  = '0;
                    st_next.rem  = '0;
                    st_next.den  = span;
                    st_next.quo  = (VW+CW)'(diff[VW-1:0]) * (VW+CW)'(period);
                end
            end
        end else begin
            st_next.quo = {st_reg.quo[VW+CW-2:0], 1'b0};
            st_next.rem = rem_s;
            if (rem_s >= {1'b0, st_reg.den}) begin
                st_next.rem    = rem_s - {1'b0, st_reg.den};
                st_next.quo[0] = 1'b1;
            end
            st_next.cnt = st_reg.cnt + 6'h01;
            if (st_reg.cnt == 6'(VW + CW - 1)) begin
                st_next.busy     = 1'b0;
                st_next.done     = 1'b1;
                st_next.on_ticks = st_next.quo[CW-1:0];           // [R7]
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign done     = st_reg.done;
    assign on_ticks = st_reg.on_ticks;

    below_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
        !st_reg.busy && start && $signed(value) < $signed(lower)
        |=> done && on_ticks == '0)
        else $error("below lower level did not give zero on-time");
    above_full_a: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
        !st_reg.busy && start && $signed(value) >= $signed(lower)
        && $signed(value) > $signed(upper) |=> done && on_ticks == $past(period))
        else $error("above upper level did not give full on-time");
    duty_bound_a: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
        $rose(st_reg.busy) |-> ##(VW+CW) done && on_ticks <= $past(period, VW+CW))
        else $error("interpolated on-time late or longer than period");
endmodule : ldpwm_duty

// *** hdl/ldpwm_output.sv ***
// Level-driven PWM drive for a solid-state relay output, APB configured
//
// What this block does
// [R1] The pulse width follows the value of one software-selected source channel.
// [R2] Duty varies with the source only while it lies between the lower and upper levels.
// [R3] A source below the lower level holds the output off for the whole period.
// [R4] A source above the upper level drives the output on for the whole period.
// [R5] An error, under-range or over-range source is replaced by the alarm level.
// [R6] The alarm level is mapped with the same lower and upper levels as the source.
// [R7] The on-time of each period divided by the period equals the computed duty.
// [R8] Pulses repeat at the set period, and a period under 0.1 s is refused.
// [R9] Once on, the output stays on for at least the minimum on time unless PWM is disabled.
// [R10] Once off, the output stays off for at least the minimum off time.
// [R11] Software should keep both minimum times strictly below the period.
// [R12] PWM runs only when the output is of the solid-state relay type.
// [R13] Inside the range duty is (source - lower) / (upper - lower).
// [R14] All times count a fixed 1 ms tick and a new duty loads at each period start.
module ldpwm_output
    import ldpwm_pkg::*;
#(
    parameter int NCH        = 60,
    parameter int VW         = 16,
    parameter int TICK_COUNT = TICK_CYCLES
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [7:0]       paddr,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [31:0]      pwdata,
    input  wire logic [3:0]       pstrb,
    output logic                  pready,
    output logic [31:0]           prdata,
    output logic                  pslverr,
    input  wire logic [NCH*VW-1:0] ch_value,
    input  wire logic [NCH-1:0]   source_error_state,
    input  wire logic [NCH-1:0]   source_under_range_state,
    input  wire logic [NCH-1:0]   source_over_range_state,
    output logic                  ssr_drive
);
    localparam int SW = $clog2(NCH);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [31:0]     rdata;
        logic            slverr;
        logic            pwm_en;
        ldpwm_out_type_t out_type;
        logic [SW-1:0]   src_sel;
        logic [VW-1:0]   lower;
        logic [VW-1:0]   upper;
        logic [VW-1:0]   alarm_level;
        logic [15:0]     period;
        logic [15:0]     min_on;
        logic [15:0]     min_off;
        logic            refused;
        logic [15:0]     pos;
        logic [15:0]     dwell;
        logic [15:0]     on_ticks;
        logic [15:0]     latest;
        logic            drive;
    } ldpwm_state_t;

    ldpwm_state_t st_reg, st_next;

    logic          tick;
    logic          duty_done;
    logic [15:0]   duty_ticks;
    logic [VW-1:0] src_raw;
    logic [VW-1:0] src_used;
    logic          src_alarm;
    logic          timing_warn;
    logic          wr_en;
    logic [31:0]   wdata;
    logic [31:0]   rd_mux;
    logic          last_pos;
    logic [15:0]   dwell_inc;
    logic [15:0]   pos_next;
    logic          want_on;

    // ****************************************
    // Address decode helpers
    // ****************************************
    function automatic logic reg_known(input logic [7:0] a);
        unique case (a)
            OFS_CTRL, OFS_SRC_SEL, OFS_LOWER, OFS_UPPER, OFS_ALARM,
            OFS_PERIOD, OFS_MIN_ON, OFS_MIN_OFF, OFS_STATUS, OFS_DUTY:
                reg_known = 1'b1;
            default: reg_known = 1'b0;
        endcase
    endfunction : reg_known

    function automatic logic reg_read_only(input logic [7:0] a);
        reg_read_only = (a == OFS_STATUS) || (a == OFS_DUTY);
    endfunction : reg_read_only

    function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        strb_merge = r;
    endfunction : strb_merge

    // ****************************************
    // Source selection and alarm substitution
    // ****************************************
    // Channel inputs come from logic on pclk, so they are used unsynchronised
    assign src_raw   = (32'(st_reg.src_sel) < NCH) ?
                       ch_value[st_reg.src_sel*VW +: VW] : '0;           // [R1]
    // A selection past the last channel is treated like a failed source
    assign src_alarm = (32'(st_reg.src_sel) >= NCH)
                     || source_error_state[st_reg.src_sel]
                     || source_under_range_state[st_reg.src_sel]
                     || source_over_range_state[st_reg.src_sel];
    assign src_used  = src_alarm ? st_reg.alarm_level : src_raw;         // [R5]

    // Warning only: equal or longer minimum times starve the pulse shape
    assign timing_warn = (st_reg.min_on >= st_reg.period)
                      || (st_reg.min_off >= st_reg.period);             // [R11]

    // ****************************************
    // Sub-blocks
    // ****************************************
    ldpwm_tick #(
        .CYCLES (TICK_COUNT)
    ) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick)
    );

    ldpwm_duty #(
        .VW (VW),
        .CW (16)
    ) u_duty (
        .pclk     (pclk),
        .presetn  (presetn),
        .start    (st_reg.pwm_en),
        .value    (src_used),                                         // [R6]
        .lower    (st_reg.lower),
        .upper    (st_reg.upper),
        .period   (st_reg.period),
        .done     (duty_done),
        .on_ticks (duty_ticks)
    );

    // ****************************************
    // APB slave
    // ****************************************
    assign wr_en = psel && penable && pwrite && !st_reg.slverr;
    assign wdata = strb_merge(rd_mux, pwdata, pstrb);

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            OFS_CTRL: begin
                rd_mux[CTRL_EN_BIT] = st_reg.pwm_en;
                rd_mux[CTRL_TYPE_LSB +: 2] = st_reg.out_type;
            end
            OFS_SRC_SEL: rd_mux[SW-1:0]  = st_reg.src_sel;
            OFS_LOWER:   rd_mux[VW-1:0]  = st_reg.lower;
            OFS_UPPER:   rd_mux[VW-1:0]  = st_reg.upper;
            OFS_ALARM:   rd_mux[VW-1:0]  = st_reg.alarm_level;
            OFS_PERIOD:  rd_mux[15:0]    = st_reg.period;
            OFS_MIN_ON:  rd_mux[15:0]    = st_reg.min_on;
            OFS_MIN_OFF: rd_mux[15:0]    = st_reg.min_off;
            OFS_STATUS: begin
                rd_mux[ST_DRIVE_BIT]   = st_reg.drive;
                rd_mux[ST_ALARM_BIT]   = src_alarm;
                rd_mux[ST_REFUSED_BIT] = st_reg.refused;
                rd_mux[ST_ACTIVE_BIT]  = st_reg.pwm_en;
                rd_mux[ST_WARN_BIT]    = timing_warn;
            end
            OFS_DUTY:    rd_mux = {st_reg.latest, st_reg.on_ticks};
            default:     rd_mux = 32'h0000_0000;
        endcase
    end

    // ****************************************
    // Next state
    // ****************************************
    assign last_pos  = (st_reg.pos >= st_reg.period - 16'h0001);
    assign pos_next  = last_pos ? 16'h0000 : st_reg.pos + 16'h0001;
    assign dwell_inc = (st_reg.dwell == 16'hFFFF) ? st_reg.dwell
                                                  : st_reg.dwell + 16'h0001;

    always_comb begin
        st_next = st_reg;
        want_on = 1'b0;

        // Read data is captured in the setup phase so the access phase needs no wait
        if (psel && !penable) begin
            st_next.rdata  = rd_mux;
            st_next.slverr = !reg_known(paddr) || (pwrite && reg_read_only(paddr));
        end

        if (wr_en) begin
            unique case (paddr)
                OFS_CTRL: begin
                    st_next.out_type = ldpwm_out_type_t'(wdata[CTRL_TYPE_LSB +: 2]);
                    // Enable sticks only on the solid-state relay type
                    st_next.pwm_en = wdata[CTRL_EN_BIT]
                        && (ldpwm_out_type_t'(wdata[CTRL_TYPE_LSB +: 2]) == OUT_SSR); // [R12]
                end
                OFS_SRC_SEL: st_next.src_sel     = wdata[SW-1:0];     // [R1]
                OFS_LOWER:   st_next.lower       = wdata[VW-1:0];     // [R2]
                OFS_UPPER:   st_next.upper       = wdata[VW-1:0];     // [R2]
                OFS_ALARM:   st_next.alarm_level = wdata[VW-1:0];
                OFS_PERIOD: begin
                    if (wdata[15:0] < MIN_PERIOD_TICKS) begin
                        st_next.refused = 1'b1;                      // [R8]
                    end else begin
                        st_next.period = wdata[15:0];
                    end
                end
                OFS_MIN_ON:  st_next.min_on  = wdata[15:0];
                OFS_MIN_OFF: st_next.min_off = wdata[15:0];
                OFS_STATUS:  begin
                end
                default: begin
                end
            endcase
        end

        // STATUS writes get an error and never raise wr_en, so this clear never runs and only reset clears the refusal flag
        if (wr_en && paddr == OFS_STATUS && wdata[ST_REFUSED_BIT]) begin
            st_next.refused = 1'b0;
        end

        if (duty_done) begin
            st_next.latest = duty_ticks;
        end

        if (!st_reg.pwm_en) begin
            st_next.pos      = 16'h0000;
            st_next.dwell    = 16'h0000;
            st_next.drive    = 1'b0;                                  // [R12]
            st_next.on_ticks = st_next.latest;
        end else if (tick) begin
            st_next.pos   = pos_next;                                 // [R8] [R14]
            st_next.dwell = dwell_inc;
            if (last_pos) begin
                st_next.on_ticks = st_reg.latest;                     // [R14]
            end
            want_on = (pos_next < st_next.on_ticks);                  // [R7] [R2]
            if (st_reg.drive && !want_on && dwell_inc >= st_reg.min_on) begin
                st_next.drive = 1'b0;                                 // [R9]
                st_next.dwell = 16'h0000;
            end else if (!st_reg.drive && want_on && dwell_inc >= st_reg.min_off) begin
                st_next.drive = 1'b1;                                 // [R10]
                st_next.dwell = 16'h0000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg          <= '0;
            st_reg.out_type <= OUT_SSR;
            st_reg.period   <= RST_PERIOD;
            st_reg.lower    <= RST_LOWER;
            st_reg.upper    <= RST_UPPER;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pready    = 1'b1;
    assign prdata    = st_reg.rdata;
    assign pslverr   = st_reg.slverr;
    assign ssr_drive = st_reg.drive;

    // ****************************************
    // Checks
    // ****************************************
    ssr_only_a: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
        st_reg.pwm_en |-> st_reg.out_type == OUT_SSR)
        else $error("PWM enabled on a non solid-state output");
    off_disabled_a: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
        !st_reg.pwm_en |=> !ssr_drive)
        else $error("output driven while PWM is disabled");
    min_on_a: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
        $fell(ssr_drive) && $past(st_reg.pwm_en)
        |-> $past(dwell_inc) >= $past(st_reg.min_on))
        else $error("output turned off before minimum on time");
    min_off_a: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
        $rose(ssr_drive) |-> $past(dwell_inc) >= $past(st_reg.min_off))
        else $error("output turned on before minimum off time");
    short_period_a: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
        wr_en && paddr == OFS_PERIOD && wdata[15:0] < MIN_PERIOD_TICKS
        |=> st_reg.refused && st_reg.period == $past(st_reg.period))
        else $error("period below the minimum was accepted");
    duty_load_a: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
        st_reg.pwm_en && tick && last_pos |=> st_reg.pos == 16'h0000
        && st_reg.on_ticks == $past(st_reg.latest))
        else $error("new duty not loaded at period start");
    alarm_sub_a: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
        source_error_state[st_reg.src_sel] || source_under_range_state[st_reg.src_sel]
        || source_over_range_state[st_reg.src_sel] |-> src_used == st_reg.alarm_level)
        else $error("alarm level not substituted for failed source");
    full_duty_a: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
        st_reg.pwm_en && tick && st_reg.drive && st_reg.on_ticks == st_reg.period
        && !last_pos |=> ssr_drive)
        else $error("output dropped during a full duty period");
endmodule : ldpwm_output

// *** hdl/ldpwm_tick.sv ***
// Fixed time-base tick generator for the PWM output
module ldpwm_tick
    import ldpwm_pkg::*;
#(
    parameter int CYCLES = TICK_CYCLES
) (
    input  wire logic pclk,
    input  wire logic presetn,
    output logic      tick
);
    typedef struct packed {
        logic [31:0] cnt;
        logic        tick;
    } ldpwm_tick_t;

    ldpwm_tick_t st_reg, st_next;

    always_comb begin
        st_next      = st_reg;
        st_next.tick = (st_reg.cnt == 32'(CYCLES - 1));
        st_next.cnt  = st_next.tick ? 32'h0000_0000 : st_reg.cnt + 32'h0000_0001;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick = st_reg.tick;
endmodule : ldpwm_tick

// *** inc/ldpwm_pkg.sv ***
// Constants, register map and field layout of the level-driven PWM output
package ldpwm_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int          CLK_PERIOD_NS = 100;
    localparam int          TICK_TIME_NS  = 1_000_000;
    localparam int          TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;
    localparam int          MIN_PERIOD_MS = 100;
    localparam logic [15:0] MIN_PERIOD_TICKS =
        16'(MIN_PERIOD_MS * 1_000_000 / TICK_TIME_NS);

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_SRC_SEL = 8'h04;
    localparam logic [7:0] OFS_LOWER   = 8'h08;
    localparam logic [7:0] OFS_UPPER   = 8'h0C;
    localparam logic [7:0] OFS_ALARM   = 8'h10;
    localparam logic [7:0] OFS_PERIOD  = 8'h14;
    localparam logic [7:0] OFS_MIN_ON  = 8'h18;
    localparam logic [7:0] OFS_MIN_OFF = 8'h1C;
    localparam logic [7:0] OFS_STATUS  = 8'h20;
    localparam logic [7:0] OFS_DUTY    = 8'h24;

    // ****************************************
    // Fields
    // ****************************************
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_TYPE_LSB  = 2;
    localparam int ST_DRIVE_BIT   = 0;
    localparam int ST_ALARM_BIT   = 1;
    localparam int ST_REFUSED_BIT = 2;
    localparam int ST_ACTIVE_BIT  = 3;
    localparam int ST_WARN_BIT    = 4;

    typedef enum logic [1:0] {
        OUT_SSR     = 2'h0,
        OUT_RELAY   = 2'h1,
        OUT_SOUND   = 2'h2,
        OUT_VIRTUAL = 2'h3
    } ldpwm_out_type_t;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [15:0] RST_PERIOD = 16'h03E8;
    localparam logic [15:0] RST_LOWER  = 16'h0000;
    localparam logic [15:0] RST_UPPER  = 16'h0064;

endpackage : ldpwm_pkg
